/* pkg/flash_status_pkg.sv */
// Package of constants for the flash write-status polling controller
package flash_status_pkg;
   // Status bit positions on the flash data bus
   localparam int unsigned DATA_POLL_BIT         = 7;
   localparam int unsigned ANY_ADDR_TOGGLE_BIT   = 6;
   localparam int unsigned TIMING_LIMIT_FAIL_BIT = 5;
   localparam int unsigned ERASE_WINDOW_BIT      = 3;
   localparam int unsigned ERASE_SECTOR_TOG_BIT  = 2;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00;
   localparam logic [7:0] ADDR_OFS   = 8'h04;
   localparam logic [7:0] WDATA_OFS  = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   localparam logic [7:0] RDATA_OFS  = 8'h10;

   // Control register command field (bits 2:0), written to start an action
   localparam logic [2:0] CMD_NONE    = 3'h0;
   localparam logic [2:0] CMD_READ    = 3'h1;
   localparam logic [2:0] CMD_WRITE   = 3'h2;
   localparam logic [2:0] CMD_POLL    = 3'h3;
   localparam logic [2:0] CMD_RESET   = 3'h4;
   localparam logic [2:0] CMD_WINDOW  = 3'h5;

   // Status register fields
   localparam int unsigned ST_BUSY      = 0;
   localparam int unsigned ST_DONE_OK   = 1;
   localparam int unsigned ST_FAILED    = 2;
   localparam int unsigned ST_SUSPENDED = 3;
   localparam int unsigned ST_IN_ERASE  = 4;
   localparam int unsigned ST_WINDOW    = 5;
   localparam int unsigned ST_RDY_PIN   = 6;

   // Reset command value written to the flash
   localparam logic [7:0] FLASH_RESET_CMD = 8'hf0;

   // Flash bus cycle timing
   localparam int unsigned CLK_MHZ       = 40;
   localparam int unsigned READ_CYCLE_NS = 55;
   localparam int unsigned WRITE_PULSE_NS = 35;
   localparam int unsigned READ_CYCLES  = (READ_CYCLE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned WRITE_CYCLES = (WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      BUS_IDLE, BUS_ACTIVE, BUS_RECOVER
   } bus_state_t;
endpackage

/* rtl/flash_bus_cycle.sv */
// Single flash read or write cycle generator on the parallel pins
`timescale 1ns/10ps
module flash_bus_cycle #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 8
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // Request side
   input  wire logic              start,
   input  wire logic              is_write,
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   output logic                   done,
   output logic [DATA_W-1:0]      rdata,
   // Flash pins
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   input  wire logic [DATA_W-1:0] flash_dq_in,
   output logic [DATA_W-1:0]      flash_dq_out,
   output logic                   flash_dq_oe
);
   flash_status_pkg::bus_state_t state_reg;
   logic [3:0]                   cnt_reg;
   logic                         wr_reg;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg    <= flash_status_pkg::BUS_IDLE;
         cnt_reg      <= 4'h0;
         wr_reg       <= 1'b0;
         flash_addr   <= '0;
         flash_ce_n   <= 1'b1;
         flash_oe_n   <= 1'b1;
         flash_we_n   <= 1'b1;
         flash_dq_out <= '0;
         flash_dq_oe  <= 1'b0;
         rdata        <= '0;
         done         <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (state_reg)
            flash_status_pkg::BUS_IDLE: begin
               if (start) begin
                  state_reg    <= flash_status_pkg::BUS_ACTIVE;
                  wr_reg       <= is_write;
                  flash_addr   <= addr;
                  flash_ce_n   <= 1'b0;
                  flash_oe_n   <= is_write;
                  flash_we_n   <= !is_write;
                  flash_dq_out <= wdata;
                  flash_dq_oe  <= is_write;
                  cnt_reg      <= is_write ? 4'(flash_status_pkg::WRITE_CYCLES)
                                           : 4'(flash_status_pkg::READ_CYCLES);
               end
            end
            flash_status_pkg::BUS_ACTIVE: begin
               if (cnt_reg > 4'h1) begin
                  cnt_reg <= cnt_reg - 4'h1;
               end else begin
                  // Each read ends with chip select and output enable high, so
                  // the flash sees a new read cycle for every poll
                  if (!wr_reg) begin
                     rdata <= flash_dq_in;
                  end
                  flash_ce_n <= 1'b1;
                  flash_oe_n <= 1'b1;
                  flash_we_n <= 1'b1;
                  state_reg  <= flash_status_pkg::BUS_RECOVER;
               end
            end
            flash_status_pkg::BUS_RECOVER: begin
               // Data held one cycle past the write strobe rising edge
               flash_dq_oe <= 1'b0;
               done        <= 1'b1;
               state_reg   <= flash_status_pkg::BUS_IDLE;
            end
         endcase
      end
   end
endmodule // flash_bus_cycle

/* rtl/flash_status_ctrl.sv */
// Host-side controller that polls flash write-operation status over AHB-Lite
`timescale 1ns/10ps
// Overview of operation
// - Host combines bit 6 and bit 2 to learn sector and mode.
// - Host reads full byte twice in a row and compares toggle bit.
// - Toggle bit steady across two reads means done; next read gives array.
// - Toggling with bit 5 high: host rechecks toggling once more.
// - Still toggling on recheck: failed, host writes reset command.
// - After pausing, host restarts toggle procedure from first double read.
// - After failure bit set, host issues reset command.
// - Host may skip bit 3 only if erase commands under 50 us apart.
// - Host reads bit 3 before and after each added sector erase.
// - Host polls at a valid program or erase-sector address.
module flash_status_ctrl #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 8
) (
   // Clock and reset
   input  wire logic              hclk,
   input  wire logic              hresetn,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic [31:0]            hrdata,
   output logic                   hreadyout,
   output logic                   hresp,
   // Flash pins
   output logic [ADDR_W-1:0]      flash_addr,
   output logic                   flash_ce_n,
   output logic                   flash_oe_n,
   output logic                   flash_we_n,
   output logic                   flash_reset_n,
   input  wire logic [DATA_W-1:0] flash_dq_in,
   output logic [DATA_W-1:0]      flash_dq_out,
   output logic                   flash_dq_oe,
   input  wire logic              ready_busy_out
);
   typedef enum logic [3:0] {
      P_IDLE, P_SINGLE, P_FIRST, P_SECOND, P_RECHECK, P_RESET_WR, P_ARRAY, P_WIN
   } poll_state_t;

   poll_state_t       state_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] prev_reg;
   logic              use_sector_reg;
   logic              busy_reg;
   logic              ok_reg;
   logic              fail_reg;
   logic              susp_reg;
   logic              in_erase_reg;
   logic              window_reg;
   logic              ph_valid_reg;
   logic              ph_write_reg;
   logic [7:0]        ph_addr_reg;
   logic              start;
   logic              cyc_write;
   logic [ADDR_W-1:0] cyc_addr;
   logic [DATA_W-1:0] cyc_wdata;
   logic              cyc_done;
   logic [DATA_W-1:0] cyc_rdata;

   function automatic logic toggled(input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
                                    input int unsigned pos);
      return a[pos] != b[pos];
   endfunction

   // Zero-wait slave; commands arriving while busy are dropped
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign flash_reset_n = 1'b1;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg  <= 8'h00;
      end else if (hready) begin
         ph_valid_reg <= hsel && htrans[1];
         ph_write_reg <= hwrite;
         ph_addr_reg  <= haddr[7:0];
      end
   end

   logic       wr_hit;
   logic [2:0] cmd;
   assign wr_hit = ph_valid_reg && ph_write_reg;
   assign cmd    = hwdata[2:0];

   logic tog_a;
   logic tog_s;
   logic fail5;
   assign tog_a = toggled(prev_reg, cyc_rdata, flash_status_pkg::ANY_ADDR_TOGGLE_BIT);
   assign tog_s = toggled(prev_reg, cyc_rdata, flash_status_pkg::ERASE_SECTOR_TOG_BIT);
   assign fail5 = cyc_rdata[flash_status_pkg::TIMING_LIMIT_FAIL_BIT];

   always_comb begin
      hrdata = 32'h0000_0000;
      if (ph_valid_reg && !ph_write_reg) begin
         unique case (ph_addr_reg)
            flash_status_pkg::CTRL_OFS:   hrdata[0] = use_sector_reg;
            flash_status_pkg::ADDR_OFS:   hrdata[ADDR_W-1:0] = addr_reg;
            flash_status_pkg::WDATA_OFS:  hrdata[DATA_W-1:0] = wdata_reg;
            flash_status_pkg::STATUS_OFS: begin
               hrdata[flash_status_pkg::ST_BUSY]      = busy_reg;
               hrdata[flash_status_pkg::ST_DONE_OK]   = ok_reg;
               hrdata[flash_status_pkg::ST_FAILED]    = fail_reg;
               hrdata[flash_status_pkg::ST_SUSPENDED] = susp_reg;
               hrdata[flash_status_pkg::ST_IN_ERASE]  = in_erase_reg;
               hrdata[flash_status_pkg::ST_WINDOW]    = window_reg;
               hrdata[flash_status_pkg::ST_RDY_PIN]   = ready_busy_out;
            end
            flash_status_pkg::RDATA_OFS:  hrdata[DATA_W-1:0] = rdata_reg;
            default:                      hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_reg       <= '0;
         wdata_reg      <= '0;
         use_sector_reg <= 1'b0;
      end else if (wr_hit && !busy_reg) begin
         if (ph_addr_reg == flash_status_pkg::ADDR_OFS) begin
            addr_reg <= hwdata[ADDR_W-1:0];
         end
         if (ph_addr_reg == flash_status_pkg::WDATA_OFS) begin
            wdata_reg <= hwdata[DATA_W-1:0];
         end
         if (ph_addr_reg == flash_status_pkg::CTRL_OFS) begin
            use_sector_reg <= hwdata[3];
         end
      end
   end

   // Cycle request decode
   always_comb begin
      start     = 1'b0;
      cyc_write = 1'b0;
      cyc_addr  = addr_reg;
      cyc_wdata = wdata_reg;
      if (wr_hit && !busy_reg && ph_addr_reg == flash_status_pkg::CTRL_OFS) begin
         start     = (cmd != flash_status_pkg::CMD_NONE);
         cyc_write = (cmd == flash_status_pkg::CMD_WRITE) ||
                     (cmd == flash_status_pkg::CMD_RESET);
         if (cmd == flash_status_pkg::CMD_RESET) begin
            cyc_wdata = flash_status_pkg::FLASH_RESET_CMD;
         end
      end else if (cyc_done) begin
         unique case (state_reg)
            P_FIRST, P_SECOND: start = 1'b1;
            // A failed recheck writes the reset command at once, so the
            // byte kept after it is array data and not a stale status byte
            P_RECHECK: begin
               start = 1'b1;
               if (tog_a) begin
                  cyc_write = 1'b1;
                  cyc_wdata = flash_status_pkg::FLASH_RESET_CMD;
               end
            end
            P_RESET_WR: start = 1'b1;
            default:    start = 1'b0;
         endcase
      end
   end

   logic take_cmd;
   logic judge;
   assign take_cmd = start && state_reg == P_IDLE;
   assign judge    = cyc_done && (state_reg == P_SECOND || state_reg == P_RECHECK);

   // Poll sequencer
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= P_IDLE;
         busy_reg  <= 1'b0;
      end else if (take_cmd) begin
         busy_reg <= 1'b1;
         unique case (cmd)
            flash_status_pkg::CMD_POLL: begin
               // Every new poll starts from the first double read
               state_reg <= P_FIRST;
            end
            flash_status_pkg::CMD_WINDOW: state_reg <= P_WIN;
            default:                      state_reg <= P_SINGLE;
         endcase
      end else if (cyc_done) begin
         unique case (state_reg)
            P_FIRST: state_reg <= P_SECOND;
            P_SECOND, P_RECHECK: begin
               if (!tog_a) begin
                  // Steady toggle bit: done; array data on next read
                  state_reg <= P_ARRAY;
               end else if (state_reg == P_RECHECK) begin
                  state_reg <= P_RESET_WR;
               end else if (fail5) begin
                  state_reg <= P_RECHECK;
               end else begin
                  state_reg <= P_SECOND;
               end
            end
            P_RESET_WR: state_reg <= P_ARRAY;
            default: begin
               state_reg <= P_IDLE;
               busy_reg  <= 1'b0;
            end
         endcase
      end
   end

   // Poll outcome; done and failed clear when the next poll starts, suspend and in-erase change only on a judged read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ok_reg       <= 1'b0;
         fail_reg     <= 1'b0;
         susp_reg     <= 1'b0;
         in_erase_reg <= 1'b0;
      end else if (take_cmd && cmd == flash_status_pkg::CMD_POLL) begin
         ok_reg   <= 1'b0;
         fail_reg <= 1'b0;
      end else if (judge) begin
         if (!tog_a) begin
            ok_reg       <= 1'b1;
            // Steady bit 6 but bit 2 toggling means erase suspended here
            susp_reg     <= tog_s;
            in_erase_reg <= 1'b0;
         end else if (state_reg == P_RECHECK) begin
            fail_reg <= 1'b1;
         end else if (!fail5) begin
            // Still busy; sector toggle tells whether this sector erases
            in_erase_reg <= tog_s;
            susp_reg     <= 1'b0;
         end
      end
   end

   // Erase window bit, refreshed only by a window read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         window_reg <= 1'b0;
      end else if (cyc_done && state_reg == P_WIN) begin
         window_reg <= cyc_rdata[flash_status_pkg::ERASE_WINDOW_BIT];
      end
   end

   // Last byte read, kept as reference for the next toggle compare
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prev_reg  <= '0;
         rdata_reg <= '0;
      end else if (cyc_done) begin
         rdata_reg <= cyc_rdata;
         prev_reg  <= cyc_rdata;
      end
   end

   flash_bus_cycle #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W)
   ) u_cycle (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .start        (start),
      .is_write     (cyc_write),
      .addr         (cyc_addr),
      .wdata        (cyc_wdata),
      .done         (cyc_done),
      .rdata        (cyc_rdata),
      .flash_addr   (flash_addr),
      .flash_ce_n   (flash_ce_n),
      .flash_oe_n   (flash_oe_n),
      .flash_we_n   (flash_we_n),
      .flash_dq_in  (flash_dq_in),
      .flash_dq_out (flash_dq_out),
      .flash_dq_oe  (flash_dq_oe)
   );
endmodule // flash_status_ctrl

/* test/flash_device_model.sv */
// Behavioural flash device answering status reads
`timescale 1ns/10ps
module flash_device_model #(
   parameter int WIN_CYC = 100
) (
   // Timer clock
   input wire logic        clk,
   // Flash pins
   input wire logic [19:0] addr,
   input wire logic        ce_n,
   input wire logic        oe_n,
   input wire logic        we_n,
   input wire logic [7:0]  dq_in,
   output logic [7:0]      dq_out,
   output logic            ready_busy_out,
   // Operation set up by the bench
   input wire logic        op_go,
   input wire logic [2:0]  op_mode,
   input wire logic [7:0]  op_reads,
   input wire logic        op_fail,
   input wire logic [3:0]  erase_sect
);
   logic [2:0] st = 3'h0;
   logic [7:0] nrd = 8'h00, last = 8'h00, wdat = 8'h00, arr, stat;
   logic       t6 = 1'b0, t2 = 1'b0, fail = 1'b0, rd_d = 1'b0, wr_d = 1'b0, sel_d = 1'b0;
   logic       sel, rd_act, wr_act;
   int         win = 0;
   assign rd_act = !ce_n && !oe_n;
   assign wr_act = !ce_n && !we_n;
   assign arr = addr[7:0] ^ 8'h5a;
   assign sel = st == 3'h3 || addr[19:16] == erase_sect;
   always_comb begin
      case (st)
         3'h1, 3'h3: stat = {1'b0, t6, fail, 1'b0, win == 0, t2 & sel, 2'b00};
         3'h2: stat = {~arr[7], t6, fail, 5'h00};
         3'h4: stat = sel ? {1'b1, t6, 3'h0, t2, 2'b00} : arr;
         default: stat = arr;
      endcase
   end
   // A released bus shows the inverse, so a stale byte cannot pass as data
   assign dq_out = rd_act ? stat : ~last;
   assign ready_busy_out = !(st inside {3'h1, 3'h2, 3'h3});
   always @(posedge clk) begin
      rd_d <= rd_act;
      wr_d <= wr_act;
      if (rd_act) begin
         last <= dq_out;
         sel_d <= sel;
      end
      if (wr_act) wdat <= dq_in;
      if (st == 3'h1 && win > 0) win <= win - 1;
      if (op_go) begin
         st <= op_mode;
         nrd <= 8'h00;
         fail <= 1'b0;
         t6 <= 1'b0;
         t2 <= 1'b0;
         win <= op_mode == 3'h1 ? WIN_CYC : 0;
      end else if (rd_d && !rd_act && st != 3'h0) begin
         t2 <= t2 ^ sel_d;
         if (st != 3'h4) begin
            t6 <= ~t6;
            nrd <= nrd + 8'h01;
            if (nrd + 8'h01 == op_reads) begin
               if (op_fail) fail <= 1'b1;
               else st <= 3'h0;
            end
         end
      end else if (wr_d && !wr_act) begin
         if (wdat == 8'hf0 && (fail || st == 3'h0)) begin
            st <= 3'h0;
            fail <= 1'b0;
         end else if (wdat == 8'h30 && st == 3'h1 && win > 0) win <= WIN_CYC;
         else if (wdat == 8'hb0 && st == 3'h1 && win == 0) st <= 3'h4;
      end
   end
endmodule // flash_device_model

/* test/flash_status_chk.sv */
// Pin-level assertions for the flash status polling controller
`timescale 1ns/10ps
module flash_status_chk #(
   parameter int ADDR_W = 20
) (
   // Clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // AHB-Lite
   input wire logic              hsel,
   input wire logic [31:0]       haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   // Flash pins
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic              flash_ce_n,
   input wire logic              flash_oe_n,
   input wire logic              flash_we_n,
   input wire logic              flash_reset_n,
   input wire logic              flash_dq_oe
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_rd_start; $fell(flash_oe_n); endsequence
   sequence s_wr_start; $fell(flash_we_n); endsequence
   sequence s_unmapped_rd;
      hsel && htrans[1] && hready && !hwrite && haddr[31:8] == 24'h0 && haddr[7:0] > 8'h10;
   endsequence
   a_read_three_cycles: assert property (
      s_rd_start |-> (!flash_oe_n)[*3] ##1 flash_oe_n) else $error("read pulse length");
   // Each read must be a separate strobe or the toggle bits never move
   a_read_recovery: assert property (
      $rose(flash_oe_n) |-> flash_ce_n ##1 flash_ce_n) else $error("no recovery cycle");
   a_write_two_cycles: assert property (
      s_wr_start |-> (!flash_we_n && !flash_ce_n)[*2] ##1 flash_we_n) else $error("write pulse");
   a_write_drives_bus: assert property (
      !flash_we_n |-> flash_dq_oe) else $error("write without data drive");
   a_write_data_hold: assert property (
      $rose(flash_we_n) |-> flash_dq_oe) else $error("write data not held");
   a_read_not_driven: assert property (
      !flash_oe_n |-> !flash_dq_oe && flash_we_n) else $error("bus driven in read");
   a_addr_steady_read: assert property (
      !flash_oe_n && !$fell(flash_oe_n) |-> $stable(flash_addr)) else $error("address moved");
   a_bus_okay: assert property (hreadyout && !hresp) else $error("bus wait or error");
   a_unmapped_zero: assert property (s_unmapped_rd |=> hrdata == 32'h0) else $error("unmapped read");
   a_reset_pin_high: assert property (flash_reset_n) else $error("flash reset pin low");
endmodule // flash_status_chk

bind flash_status_ctrl flash_status_chk #(.ADDR_W(ADDR_W)) i_flash_status_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .flash_addr(flash_addr), .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_reset_n(flash_reset_n), .flash_dq_oe(flash_dq_oe));

/* test/flash_status_ctrl_bench.sv */
// Self-checking bench for the flash status polling controller
`timescale 1ns/10ps
module flash_status_ctrl_bench;
   localparam logic [7:0] STO = flash_status_pkg::STATUS_OFS;
   localparam logic [7:0] RDO = flash_status_pkg::RDATA_OFS;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, op_go = 1'b0;
   logic        op_fail = 1'b0, hready, hreadyout, hresp, ce_n, oe_n, we_n, rst_n, dq_oe, rdy;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010, op_mode = 3'h0;
   logic [19:0] faddr;
   logic [7:0]  dq_out, dq_model, dq_bus, op_reads = 8'h00;
   logic [3:0]  erase_sect = 4'h0;
   int          err_total = 0, checks = 0, cyc = 0;
   assign hready = hreadyout;
   assign dq_bus = dq_oe ? dq_out : dq_model;
   always #12.5 hclk = ~hclk;
   flash_status_ctrl #(.ADDR_W(20), .DATA_W(8)) i_flash_status_ctrl (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .flash_addr(faddr), .flash_ce_n(ce_n),
      .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_reset_n(rst_n), .flash_dq_in(dq_bus),
      .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .ready_busy_out(rdy));
   // Short window keeps the run brief; the waits below are sized from it
   flash_device_model #(.WIN_CYC(100)) i_flash_device_model (
      .clk(hclk), .addr(faddr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_bus),
      .dq_out(dq_model), .ready_busy_out(rdy), .op_go(op_go), .op_mode(op_mode),
      .op_reads(op_reads), .op_fail(op_fail), .erase_sect(erase_sect));
   task automatic report_and_stop();
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task automatic do_cmd(input logic [2:0] cmd, input logic [19:0] a, input logic [7:0] wd);
      int n;
      ahb(1'b1, flash_status_pkg::ADDR_OFS, {12'h0, a});
      ahb(1'b1, flash_status_pkg::WDATA_OFS, {24'h0, wd});
      ahb(1'b1, flash_status_pkg::CTRL_OFS, {29'h0, cmd});
      n = 0;
      do begin
         ahb(1'b0, STO, 32'h0);
         n++;
      end while (rd[flash_status_pkg::ST_BUSY] !== 1'b0 && n < 500);
   endtask
   task automatic start_op(input logic [2:0] m, input logic [7:0] n, input logic f,
                           input logic [3:0] s);
      op_mode <= m;
      op_reads <= n;
      op_fail <= f;
      erase_sect <= s;
      op_go <= 1'b1;
      @(posedge hclk);
      op_go <= 1'b0;
   endtask
   task automatic check_rdata(input string what, input logic [19:0] a);
      ahb(1'b0, RDO, 32'h0);
      check(what, rd & 32'hff, {24'h0, a[7:0] ^ 8'h5a});
   endtask
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         report_and_stop();
      end
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, STO, 32'h0);
      check("status_rst", rd & 32'h3f, 32'h0);
      ahb(1'b1, 8'h14, 32'hffffffff);
      ahb(1'b0, 8'h14, 32'h0);
      check("unmapped", rd, 32'h0);
      do_cmd(flash_status_pkg::CMD_READ, 20'h12345, 8'h00);
      check_rdata("idle_rd", 20'h12345);
      start_op(3'h2, 8'd3, 1'b0, 4'h0);
      do_cmd(flash_status_pkg::CMD_POLL, 20'h12345, 8'h00);
      check("prog_ok", rd & 32'h7, 32'h2);
      check_rdata("prog_rd", 20'h12345);
      start_op(3'h2, 8'd2, 1'b1, 4'h0);
      do_cmd(flash_status_pkg::CMD_POLL, 20'h12345, 8'h00);
      check("prog_fail", rd & 32'h47, 32'h44);
      check_rdata("fail_rd", 20'h12345);
      start_op(3'h1, 8'hff, 1'b0, 4'h3);
      do_cmd(flash_status_pkg::CMD_WINDOW, 20'h30010, 8'h00);
      check("win_open", rd & 32'h60, 32'h0);
      do_cmd(flash_status_pkg::CMD_WRITE, 20'h30010, 8'h30);
      repeat (70) @(posedge hclk);
      do_cmd(flash_status_pkg::CMD_WINDOW, 20'h30010, 8'h00);
      check("win_restart", rd & 32'h20, 32'h0);
      repeat (60) @(posedge hclk);
      do_cmd(flash_status_pkg::CMD_WINDOW, 20'h30010, 8'h00);
      check("win_closed", rd & 32'h20, 32'h20);
      do_cmd(flash_status_pkg::CMD_WRITE, 20'h30010, 8'hb0);
      do_cmd(flash_status_pkg::CMD_POLL, 20'h30010, 8'h00);
      check("suspend", rd & 32'h48, 32'h48);
      do_cmd(flash_status_pkg::CMD_READ, 20'h50077, 8'h00);
      check_rdata("susp_rd", 20'h50077);
      start_op(3'h2, 8'd1, 1'b1, 4'h0);
      do_cmd(flash_status_pkg::CMD_READ, 20'h12345, 8'h00);
      do_cmd(flash_status_pkg::CMD_RESET, 20'h12345, 8'h00);
      do_cmd(flash_status_pkg::CMD_READ, 20'h12345, 8'h00);
      check_rdata("reset_rd", 20'h12345);
      start_op(3'h3, 8'hff, 1'b0, 4'h0);
      do_cmd(flash_status_pkg::CMD_WINDOW, 20'h70000, 8'h00);
      check("chip_win", rd & 32'h20, 32'h20);
      report_and_stop();
   end
endmodule // flash_status_ctrl_bench
